// ===== dv/mcsel_checker.sv
/* Assertions on the link lines and on the scanner end's ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module mcsel_checker #(
    parameter int unsigned CYC_PER_MS = 10
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [2:0] case_sel,
    input wire logic safety_output_a,
    input wire logic safety_output_b,
    input wire logic npn_mode_i,
    input wire logic [2:0] num_cases_i,
    input wire logic [9:0] delay_ms_i,
    input wire logic field_clear_i,
    input wire logic device_fault_i,
    input wire logic [1:0] active_case_o,
    input wire logic case_error_o,
    input wire logic delay_busy_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    int unsigned cnt;
    // Counts the cycles that the masking window has stood so far.
    always_ff @(posedge clock_i)
    begin
        cnt <= (rst_i || !delay_busy_o) ? 0 : cnt + 1;
    end
    sequence sel_moved;
        !$stable(case_sel) && !delay_busy_o && num_cases_i > 3'h1;
    endsequence
    a_pair_same: assert property (
        safety_output_a == safety_output_b) else $error("outputs differ");
    a_clear_on: assert property (
        !rst_i && field_clear_i && !device_fault_i ##1 !case_error_o
        |-> safety_output_a != npn_mode_i) else $error("not on");
    a_fault_off: assert property (
        !rst_i && device_fault_i |=> safety_output_a == npn_mode_i)
        else $error("not off on fault");
    a_error_off: assert property (
        case_error_o |-> safety_output_a == npn_mode_i)
        else $error("not off on error");
    a_single_case: assert property (
        num_cases_i == 3'h1 |-> active_case_o == 2'h0 && !case_error_o)
        else $error("single case left");
    a_delay_len: assert property (
        $fell(delay_busy_o) |-> cnt + 1 >= delay_ms_i * CYC_PER_MS
        && cnt <= delay_ms_i * CYC_PER_MS + 1) else $error("delay length");
    a_delay_hold: assert property (
        delay_busy_o && $past(delay_busy_o) |-> $stable(active_case_o))
        else $error("case moved in delay");
    a_sync_start: assert property (
        sel_moved |-> ##[1:4] delay_busy_o) else $error("delay not started");
endmodule : mcsel_checker
`default_nettype wire

// ===== dv/testbench.sv
/* Testbench: both ends joined by the link; APB and scanner inputs
   driven here. Assumes the shortened millisecond count CPM. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int unsigned CPM = 10;
    logic clk = 1'b0, rst = 1'b1, npn = 1'b0, clr = 1'b1, flt = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [2:0] nc = 3'h1;
    logic [7:0] pad = 8'h00;
    logic [31:0] pwd = 32'h0000_0000, prd, rd;
    logic prdy, perr, serr, stop, irq, cerr, busy, i0;
    logic [1:0] acs;
    logic [9:0] dly = 10'h00a;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    mcsel_if lnk ();
    wire logic [7:0] outs = {6'h0, lnk.safety_output_a, lnk.safety_output_b};
    mcsel_dev #(.CYC_PER_MS(CPM)) u_mcsel_dev (.clock_i(clk), .rst_i(rst),
        .link(lnk), .npn_mode_i(npn), .num_cases_i(nc),
        .delay_ms_i(dly), .field_clear_i(clr), .device_fault_i(flt),
        .active_case_o(acs), .case_error_o(cerr), .delay_busy_o(busy));
    mcsel_ctl #(.CYC_PER_MS(CPM)) u_mcsel_ctl (.clock_i(clk), .rst_i(rst),
        .link(lnk), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(pad), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
        .pslverr_o(perr), .safe_stop_o(stop), .irq_o(irq));
    mcsel_checker #(.CYC_PER_MS(CPM)) u_mcsel_checker (.clock_i(clk),
        .rst_i(rst), .case_sel(lnk.case_sel), .npn_mode_i(npn),
        .safety_output_a(lnk.safety_output_a), .num_cases_i(nc),
        .safety_output_b(lnk.safety_output_b), .delay_ms_i(dly),
        .field_clear_i(clr), .device_fault_i(flt), .active_case_o(acs),
        .case_error_o(cerr), .delay_busy_o(busy));
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
            close_out(1);
    end
    task close_out(input int late);
        error_cnt = error_cnt + late;
        $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    task chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count = cmp_count + 1;
        if (g !== e)
        begin
            error_cnt = error_cnt + 1;
            $display("FAIL at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pad <= a;
        pwd <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (prdy !== 1'b1);
        rd = prd;
        serr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task cfg(input logic [2:0] n, input logic p);
        nc <= n;
        npn <= p;
        flt <= 1'b0;
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
    endtask : cfg
    // Writes a pattern, waits out sync plus the set delay, checks.
    task sel(input logic [2:0] p, input logic [1:0] ec, input logic ee);
        apb(1'b1, mcsel_pkg::ADDR_CTRL, {3'h0, npn, 1'b0, p});
        repeat (int'(dly) * CPM + 30) @(posedge clk);
        chk({7'h0, cerr}, {7'h0, ee});
        if (!ee)
            chk({6'h0, acs}, {6'h0, ec});
        chk(outs, {6'h0, {2{(!ee && clr && !flt) ^ npn}}});
    endtask : sel
    initial
    begin
        cfg(3'h1, 1'b0);
        sel(3'h6, 2'h0, 1'b0);
        $display("test single done");
        cfg(3'h2, 1'b0);
        sel(3'h5, 2'h0, 1'b0);
        sel(3'h2, 2'h1, 1'b0);
        sel(3'h3, 2'h0, 1'b1);
        sel(3'h6, 2'h1, 1'b0);
        $display("test two done");
        dly <= 10'h014;
        cfg(3'h3, 1'b0);
        sel(3'h4, 2'h2, 1'b0);
        sel(3'h7, 2'h0, 1'b1);
        apb(1'b1, mcsel_pkg::ADDR_CTRL, 8'h02);
        repeat (50) @(posedge clk);
        chk({4'h0, cerr, busy, acs}, 8'h0E);
        sel(3'h1, 2'h0, 1'b0);
        dly <= 10'h00a;
        cfg(3'h4, 1'b0);
        sel(3'h7, 2'h3, 1'b0);
        $display("test decode done");
        cfg(3'h1, 1'b1);
        sel(3'h1, 2'h0, 1'b0);
        flt <= 1'b1;
        repeat (5) @(posedge clk);
        chk(outs, 8'h03);
        $display("test sinking done");
        cfg(3'h1, 1'b0);
        sel(3'h1, 2'h0, 1'b0);
        apb(1'b1, mcsel_pkg::ADDR_IRQ_STAT, 8'h03);
        clr <= 1'b0;
        repeat (5) @(posedge clk);
        chk(outs, 8'h00);
        apb(1'b0, mcsel_pkg::ADDR_STATUS, 8'h00);
        chk({3'h0, stop, rd[3:0]}, 8'h14);
        apb(1'b0, mcsel_pkg::ADDR_IRQ_STAT, 8'h00);
        chk(rd[7:0] & 8'h01, 8'h01);
        apb(1'b1, mcsel_pkg::ADDR_IRQ_MASK, 8'h00);
        repeat (2) @(posedge clk);
        i0 = irq;
        apb(1'b1, mcsel_pkg::ADDR_IRQ_MASK, 8'h03);
        repeat (2) @(posedge clk);
        chk({7'h0, irq ^ i0}, 8'h01);
        clr <= 1'b1;
        apb(1'b1, mcsel_pkg::ADDR_IRQ_STAT, 8'h01);
        apb(1'b0, mcsel_pkg::ADDR_IRQ_STAT, 8'h00);
        chk(rd[7:0] & 8'h01, 8'h00);
        apb(1'b0, mcsel_pkg::ADDR_CTRL, 8'h00);
        chk(rd[7:0], 8'h01);
        apb(1'b0, mcsel_pkg::ADDR_DISC, 8'h00);
        chk(rd[7:0], 8'(mcsel_pkg::DISC_DEF_MS));
        apb(1'b0, 8'h20, 8'h00);
        chk({serr, rd[6:0]}, 8'h80);
        $display("test controller done");
        close_out(0);
    end
endmodule : testbench
`default_nettype wire

// ===== hw/mcsel_ctl.sv
/*
 * Controller end: drives the case-select lines from an APB register,
 * evaluates the two safety outputs as separate channels and raises an
 * interrupt on a trip or a channel discrepancy.
 * Assumes an APB master on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module mcsel_ctl #(
    parameter int unsigned CYC_PER_MS = mcsel_pkg::CYC_PER_MS
) (
    input wire logic clock_i,
    input wire logic rst_i,
    mcsel_if.ctl link,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic safe_stop_o,
    output logic irq_o
);
    typedef struct packed {
        logic [1:0] sa;
        logic [1:0] sb;
        logic [2:0] sel;
        logic npn;
        logic [9:0] disc_ms;
        logic [31:0] cyc;
        logic [9:0] dcnt;
        logic stop;
        logic disc;
        logic [1:0] ist;
        logic [1:0] imask;
        logic irq;
        logic [31:0] rdata;
        logic rdy;
        logic err;
    } mcsel_ctl_state_t;

    mcsel_ctl_state_t s_reg;
    mcsel_ctl_state_t s_next;

    logic a_off;
    logic b_off;
    logic acc;
    logic wr;
    logic [1:0] ev;

    always_comb
    begin
        s_next = s_reg;
        s_next.sa = {s_reg.sa[0], link.safety_output_a};
        s_next.sb = {s_reg.sb[0], link.safety_output_b};
        a_off = s_reg.sa[1] ^ s_reg.npn ? 1'b0 : 1'b1;
        b_off = s_reg.sb[1] ^ s_reg.npn ? 1'b0 : 1'b1;
        ev = 2'b00;
        s_next.stop = a_off | b_off;
        ev[mcsel_pkg::IRQ_TRIP] = s_next.stop & ~s_reg.stop;
        if (a_off != b_off)
        begin
            if (s_reg.cyc == 32'(CYC_PER_MS - 1))
            begin
                s_next.cyc = 32'h0000_0000;
                if (s_reg.dcnt >= s_reg.disc_ms)
                begin
                    s_next.disc = 1'b1;
                    ev[mcsel_pkg::IRQ_DISC] = ~s_reg.disc;
                end
                else
                begin
                    s_next.dcnt = s_reg.dcnt + 10'h001;
                end
            end
            else
            begin
                s_next.cyc = s_reg.cyc + 32'h0000_0001;
            end
        end
        else
        begin
            s_next.cyc = 32'h0000_0000;
            s_next.dcnt = 10'h000;
            s_next.disc = 1'b0;
        end
        acc = psel_i & penable_i & ~s_reg.rdy;
        wr = psel_i & penable_i & pwrite_i & s_reg.rdy;
        s_next.rdy = acc;
        s_next.err = 1'b0;
        // A write lands only on the edge at which pready is seen high.
        if (wr)
        begin
            unique case (paddr_i)
                mcsel_pkg::ADDR_CTRL:
                begin
                    s_next.sel = pwdata_i[2:0];
                    s_next.npn = pwdata_i[4];
                end
                mcsel_pkg::ADDR_IRQ_STAT:
                    s_next.ist = s_reg.ist & ~pwdata_i[1:0];
                mcsel_pkg::ADDR_IRQ_MASK: s_next.imask = pwdata_i[1:0];
                mcsel_pkg::ADDR_DISC: s_next.disc_ms = pwdata_i[9:0];
                default: s_next.err = 1'b0;
            endcase
        end
        // Read data and the error flag are registered on the same edge that raises pready.
        if (acc)
        begin
            unique case (paddr_i)
                mcsel_pkg::ADDR_CTRL:
                    s_next.rdata = {27'h0, s_reg.npn, 1'b0, s_reg.sel};
                mcsel_pkg::ADDR_STATUS:
                begin
                    s_next.rdata = {28'h0, s_reg.disc, s_reg.stop,
                        ~b_off, ~a_off};
                    s_next.err = pwrite_i;
                end
                mcsel_pkg::ADDR_IRQ_STAT: s_next.rdata = {30'h0, s_reg.ist};
                mcsel_pkg::ADDR_IRQ_MASK: s_next.rdata = {30'h0, s_reg.imask};
                mcsel_pkg::ADDR_DISC: s_next.rdata = {22'h0, s_reg.disc_ms};
                default:
                begin
                    s_next.rdata = 32'h0000_0000;
                    s_next.err = 1'b1;
                end
            endcase
        end
        // New events win over a clear in the same cycle.
        s_next.ist = s_next.ist | ev;
        s_next.irq = |(s_next.ist & s_next.imask);
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
            s_reg.stop <= 1'b1;
            s_reg.sa <= 2'b00;
            s_reg.sb <= 2'b00;
            s_reg.sel <= mcsel_pkg::CASES_RESET;
            s_reg.disc_ms <= 10'(mcsel_pkg::DISC_DEF_MS);
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign link.case_sel = s_reg.sel;
    assign prdata_o = s_reg.rdata;
    assign pready_o = s_reg.rdy;
    assign pslverr_o = s_reg.err;
    assign safe_stop_o = s_reg.stop;
    assign irq_o = s_reg.irq;
endmodule : mcsel_ctl
`default_nettype wire

// ===== hw/mcsel_dev.sv
/*
 * Scanner end: decodes the case-select lines into a monitoring case,
 * masks changes for the switch-on delay, flags invalid patterns and
 * drives the safety output pair in the chosen polarity.
 * Assumes the configuration inputs are static from this clock domain.
 */
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Polarity selectable, both outputs share it.
// - Sourcing: clear field high, otherwise low.
// - Sinking: clear field low, otherwise high.
// - Polarity resets to sourcing mode.
// - Controller trips when any output goes off.
// - Controller checks channels apart with discrepancy limit.
// - Single case ignores all select lines.
// - Two cases decode a and b only.
// - Three or more cases decode all lines.
// - All ones is case four only.
// - Unmapped pattern raises recoverable error.
// - No pattern check with one case.
// - Valid pattern clears error and selects case.
// - Case order is the driver's concern.
// - Switch-on delay settable ten to five hundred.
// - After a change, inputs ignored for delay.
// - Driver settles lines within the delay.
module mcsel_dev #(
    parameter int unsigned CYC_PER_MS = mcsel_pkg::CYC_PER_MS
) (
    input wire logic clock_i,
    input wire logic rst_i,
    mcsel_if.dev link,
    input wire logic npn_mode_i,
    input wire logic [2:0] num_cases_i,
    input wire logic [9:0] delay_ms_i,
    input wire logic field_clear_i,
    input wire logic device_fault_i,
    output logic [1:0] active_case_o,
    output logic case_error_o,
    output logic delay_busy_o
);
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] last;
        logic busy;
        logic [31:0] cyc;
        logic [9:0] ms;
        logic [1:0] act;
        logic err;
        logic pol;
        logic out_a;
        logic out_b;
    } mcsel_dev_state_t;

    mcsel_dev_state_t s_reg;
    mcsel_dev_state_t s_next;

    function automatic logic [9:0] clamp_delay(input logic [9:0] d);
        logic [9:0] r;
        r = d;
        if (d < 10'(mcsel_pkg::DELAY_MIN_MS))
        begin
            r = 10'(mcsel_pkg::DELAY_MIN_MS);
        end
        else if (d > 10'(mcsel_pkg::DELAY_MAX_MS))
        begin
            r = 10'(mcsel_pkg::DELAY_MAX_MS);
        end
        return r;
    endfunction : clamp_delay

    logic ok;
    logic [1:0] dec;
    logic on_state;

    always_comb
    begin
        ok = 1'b0;
        dec = 2'h0;
        on_state = 1'b0;
        s_next = s_reg;
        s_next.sync1 = link.case_sel;
        s_next.sync2 = s_reg.sync1;
        s_next.pol = npn_mode_i;
        // Decode the synchronised pattern for the configured case count.
        if (num_cases_i <= 3'd1)
        begin
            ok = 1'b1;
            dec = 2'h0;
        end
        else if (num_cases_i == 3'd2)
        begin
            ok = s_reg.sync2[0] ^ s_reg.sync2[1];
            dec = s_reg.sync2[1] ? 2'h1 : 2'h0;
        end
        else
        begin
            unique case (s_reg.sync2)
                3'b001: begin ok = 1'b1; dec = 2'h0; end
                3'b010: begin ok = 1'b1; dec = 2'h1; end
                3'b100: begin ok = 1'b1; dec = 2'h2; end
                3'b111:
                begin
                    ok = (num_cases_i >= 3'd4);
                    dec = 2'h3;
                end
                default: begin ok = 1'b0; dec = 2'h0; end
            endcase
        end
        // Bit 0 of the bus is input a, bit 1 is b, bit 2 is c.
        if (num_cases_i <= 3'd1)
        begin
            s_next.busy = 1'b0;
            s_next.err = 1'b0;
            s_next.act = 2'h0;
            s_next.last = s_reg.sync2;
        end
        else if (s_reg.busy)
        begin
            if (s_reg.cyc == 32'(CYC_PER_MS - 1))
            begin
                s_next.cyc = 32'h0000_0000;
                if (s_reg.ms == 10'h001)
                begin
                    s_next.busy = 1'b0;
                    s_next.last = s_reg.sync2;
                    s_next.err = ~ok;
                    if (ok)
                    begin
                        s_next.act = dec;
                    end
                end
                s_next.ms = s_reg.ms - 10'h001;
            end
            else
            begin
                s_next.cyc = s_reg.cyc + 32'h0000_0001;
            end
        end
        else if (s_reg.sync2 != s_reg.last)
        begin
            s_next.busy = 1'b1;
            s_next.cyc = 32'h0000_0000;
            s_next.ms = clamp_delay(delay_ms_i);
        end
        else
        begin
            s_next.err = ~ok;
            if (ok)
            begin
                s_next.act = dec;
            end
        end
        on_state = field_clear_i & ~device_fault_i & ~s_next.err;
        s_next.out_a = s_next.pol ? ~on_state : on_state;
        s_next.out_b = s_next.pol ? ~on_state : on_state;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
            s_reg.pol <= mcsel_pkg::POL_RESET;
            // History starts at the lines' idle pattern, so no false change.
            s_reg.sync1 <= mcsel_pkg::CASES_RESET;
            s_reg.sync2 <= mcsel_pkg::CASES_RESET;
            s_reg.last <= mcsel_pkg::CASES_RESET;
            s_reg.out_a <= 1'b0;
            s_reg.out_b <= 1'b0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign link.safety_output_a = s_reg.out_a;
    assign link.safety_output_b = s_reg.out_b;
    assign active_case_o = s_reg.act;
    assign case_error_o = s_reg.err;
    assign delay_busy_o = s_reg.busy;
endmodule : mcsel_dev
`default_nettype wire

// ===== hw/mcsel_if.sv
/*
 * Link between the scanner end and the safety controller end.
 * Carries the three case-select lines and the two safety outputs.
 */
`timescale 1ns/1ps
`default_nettype none
interface mcsel_if;
    logic [2:0] case_sel;
    logic safety_output_a;
    logic safety_output_b;

    modport dev (input case_sel, output safety_output_a, safety_output_b);
    modport ctl (output case_sel, input safety_output_a, safety_output_b);
endinterface : mcsel_if
`default_nettype wire

// ===== hw/mcsel_pkg.sv
/*
 * Package for the monitoring case select and safety output block.
 * Holds the timing figures, the polarity and case encodings and the
 * register map used by the controller end. Assumes a 100 MHz clock.
 */
package mcsel_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned DELAY_MIN_MS = 10;
    localparam int unsigned DELAY_MAX_MS = 500;
    localparam int unsigned DELAY_DEF_MS = 10;
    localparam int unsigned DISC_DEF_MS = 20;

    localparam logic POL_PNP = 1'b0;
    localparam logic POL_NPN = 1'b1;
    localparam logic POL_RESET = POL_PNP;

    localparam logic [2:0] CASES_RESET = 3'h1;
    localparam logic [1:0] CASE_RESET = 2'h0;

    // Controller register map, byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_DISC = 8'h10;

    localparam int unsigned IRQ_TRIP = 0;
    localparam int unsigned IRQ_DISC = 1;
    localparam int unsigned IRQ_W = 2;
endpackage : mcsel_pkg
